// ==== core/bcc_defs.vh ====
// bcc_defs.vh: timing constants for the bridge chopper current control
// assumes a 25 MHz core clock; counts derived from times in ns
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH
`define BCC_CLK_PERIOD_NS 40
// shoot_through_gap, least time, rounded up
`define BCC_GAP_NS 1000
`define BCC_GAP_CYC ((`BCC_GAP_NS + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
// blanking after turn-on, least time, rounded up
`define BCC_BLANK_NS 1000
`define BCC_BLANK_CYC ((`BCC_BLANK_NS + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
// minimum on time, least time, rounded up
`define BCC_TON_MIN_NS 1500
`define BCC_TON_MIN_CYC ((`BCC_TON_MIN_NS + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
// default one-shot time for a 20k/1n timing network (0.6*R*C = 12 us)
`define BCC_TOFF_NS 12000
`define BCC_TOFF_CYC (`BCC_TOFF_NS / `BCC_CLK_PERIOD_NS)
`define BCC_CNT_W 16
`endif

// ==== core/bcc_bridge.v ====
// bcc_bridge.v: one full-bridge constant off-time chopper
// assumes comparator and control inputs are already synchronised to clock
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.vh"
module bcc_bridge #(
  parameter CNT_W = `BCC_CNT_W,
  parameter [CNT_W-1:0] GAP_CYC = `BCC_GAP_CYC,
  parameter [CNT_W-1:0] BLANK_CYC = `BCC_BLANK_CYC,
  parameter [CNT_W-1:0] TON_MIN_CYC = `BCC_TON_MIN_CYC,
  parameter [CNT_W-1:0] TOFF_CYC = `BCC_TOFF_CYC
) (
  input wire clock,
  input wire resetn,
  input wire enable,
  input wire phase,
  input wire slow_decay,
  input wire over_ref,
  output reg hs1_reg,
  output reg ls1_reg,
  output reg hs2_reg,
  output reg ls2_reg,
  output reg chopping_reg
);
  // -------------------------------------------------
  // states
  // -------------------------------------------------
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_GAPON = 5'b00010;
  localparam [4:0] S_ON = 5'b00100;
  localparam [4:0] S_GAPOFF = 5'b01000;
  localparam [4:0] S_RECT = 5'b10000;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg [CNT_W-1:0] ton_reg;
  reg [CNT_W-1:0] shot_reg;
  reg [CNT_W-1:0] shot_next;
  reg dir_reg;
  reg slow_reg;
  wire trip;
  wire drive_on;

  // blank and minimum on time both gate the comparator
  assign trip = over_ref && (ton_reg >= BLANK_CYC) && (ton_reg >= TON_MIN_CYC);

  // -------------------------------------------------
  // sequencer
  // -------------------------------------------------
  // gap state precedes every turn-on; one-shot keeps running through
  // the gap so that off time is one-shot plus one gap
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shot_next = (shot_reg != {CNT_W{1'b0}}) ? shot_reg - 1'b1 : shot_reg;
    case (state_reg)
      S_IDLE:
      begin
        cnt_next = GAP_CYC;
        state_next = S_GAPON;
      end
      S_GAPON:
      begin
        // restore only after the gap once rectifier released
        if (cnt_reg <= 1)
          state_next = S_ON;
        else
          cnt_next = cnt_reg - 1'b1;
      end
      S_ON:
      begin
        if (trip || dir_reg != phase)
        begin
          state_next = S_GAPOFF;
          cnt_next = GAP_CYC;
          shot_next = trip ? TOFF_CYC : {CNT_W{1'b0}};
        end
      end
      S_GAPOFF:
      begin
        if (cnt_reg <= 1)
          state_next = (shot_reg == {CNT_W{1'b0}}) ? S_IDLE : S_RECT;
        else
          cnt_next = cnt_reg - 1'b1;
      end
      S_RECT:
      begin
        // stay off until the one-shot runs out
        if (shot_reg <= 1)
        begin
          state_next = S_GAPON;
          cnt_next = GAP_CYC;
        end
      end
      default:
        state_next = S_IDLE;
    endcase
  end

  // state registers; enable low forces idle
  always @(posedge clock)
  begin
    if (!resetn || !enable)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      shot_reg <= {CNT_W{1'b0}};
      ton_reg <= {CNT_W{1'b0}};
      dir_reg <= 1'b0;
      slow_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shot_reg <= shot_next;
      // saturating on-time counter, cleared whenever not conducting
      if (state_reg == S_ON && ton_reg != {CNT_W{1'b1}})
        ton_reg <= ton_reg + 1'b1;
      else if (state_reg != S_ON)
        ton_reg <= {CNT_W{1'b0}};
      if (state_reg == S_IDLE)
        dir_reg <= phase;
      // decay mode latched at off-time start, stable for whole off phase
      if (state_reg == S_ON)
        slow_reg <= slow_decay;
    end
  end

  // -------------------------------------------------
  // gate drive
  // -------------------------------------------------
  // dir 1: hs1+ls2 conduct; dir 0: hs2+ls1 conduct
  assign drive_on = (state_reg == S_ON);

  always @(posedge clock)
  begin
    if (!resetn || !enable)
    begin
      hs1_reg <= 1'b0;
      ls1_reg <= 1'b0;
      hs2_reg <= 1'b0;
      ls2_reg <= 1'b0;
      chopping_reg <= 1'b0;
    end
    else
    begin
      chopping_reg <= (state_next == S_GAPOFF && state_reg == S_ON && trip) ||
        (state_reg == S_GAPOFF && shot_reg != 0) || state_reg == S_RECT;
      case (state_next)
        S_ON:
        begin
          hs1_reg <= dir_reg;
          ls2_reg <= dir_reg;
          hs2_reg <= !dir_reg;
          ls1_reg <= !dir_reg;
        end
        S_GAPOFF:
        begin
          // fast: both off; slow: only low side off
          hs1_reg <= (state_reg == S_ON) && trip && slow_decay && dir_reg;
          hs2_reg <= (state_reg == S_ON) && trip && slow_decay && !dir_reg;
          if (state_reg != S_ON)
          begin
            hs1_reg <= hs1_reg;
            hs2_reg <= hs2_reg;
          end
          ls1_reg <= 1'b0;
          ls2_reg <= 1'b0;
        end
        S_RECT:
        begin
          if (slow_reg)
          begin
            hs1_reg <= 1'b1;
            hs2_reg <= 1'b1;
            ls1_reg <= 1'b0;
            ls2_reg <= 1'b0;
          end
          else
          begin
            // only the low side across the conducting diode
            hs1_reg <= 1'b0;
            hs2_reg <= 1'b0;
            ls1_reg <= dir_reg;
            ls2_reg <= !dir_reg;
          end
        end
        S_GAPON:
        begin
          // rectifier released; in slow decay the conducting high
          // side stays on, the other one is released
          hs1_reg <= hs1_reg && slow_reg && dir_reg;
          hs2_reg <= hs2_reg && slow_reg && !dir_reg;
          ls1_reg <= 1'b0;
          ls2_reg <= 1'b0;
        end
        default:
        begin
          hs1_reg <= 1'b0;
          ls1_reg <= 1'b0;
          hs2_reg <= 1'b0;
          ls2_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/bcc_top.v ====
// bcc_top.v: dual-bridge constant off-time chopping controller
// assumes comparator outputs, enable pin and decay select are async pins
//
// Overview of operation
// - A gap separates turning off one switch of a leg and turning on its partner.
// - Two independent choppers exist, one per bridge, each with its own sense input.
// - Sense above reference fires the one-shot which switches the bridge off at once.
// - The bridge stays off for the whole one-shot and turns on only after it expires.
// - The effective off time is the one-shot time plus one gap.
// - The comparator is ignored for a blanking time after turn-on.
// - A bridge once on is not chopped off by the comparator before the minimum on time; a phase change switches it off at once.
// - Decay select low gives fast decay: both conducting switches turn off.
// - Decay select high gives slow decay: only the low-side switch turns off.
// - Fast decay rectifies with the low side beside the conducting diode only.
// - Fast decay restores the on state one gap after the rectifier is released.
// - Slow decay turns on the opposite high side as rectifier after the gap.
// - Slow decay re-enables the low side one gap after the rectifier is released.
// - On overcurrent or overheating the device pulls the enable pin low itself.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.vh"
module bcc_top #(
  parameter CNT_W = `BCC_CNT_W,
  parameter [CNT_W-1:0] TOFF_A_CYC = `BCC_TOFF_CYC,
  parameter [CNT_W-1:0] TOFF_B_CYC = `BCC_TOFF_CYC
) (
  input wire clock,
  input wire resetn,
  input wire enable_in,
  output wire enable_out,
  output wire enable_oe,
  input wire fault_overcurrent,
  input wire fault_thermal,
  input wire slow_decay,
  input wire phase_a,
  input wire phase_b,
  input wire over_ref_a,
  input wire over_ref_b,
  output wire hs1_a,
  output wire ls1_a,
  output wire hs2_a,
  output wire ls2_a,
  output wire chopping_a,
  output wire hs1_b,
  output wire ls1_b,
  output wire hs2_b,
  output wire ls2_b,
  output wire chopping_b
);
  // -------------------------------------------------
  // input synchronisers
  // -------------------------------------------------
  // bit order: ref a, ref b, phase a, phase b, decay, enable, overcurrent, thermal
  localparam NSYNC = 8;
  reg [NSYNC-1:0] meta_reg;
  reg [NSYNC-1:0] sync_reg;
  reg pull_reg;

  // two flops per pin; first stage feeds nothing but the second
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end
    else
    begin
      meta_reg <= {fault_thermal, fault_overcurrent, enable_in, slow_decay,
        phase_b, phase_a, over_ref_b, over_ref_a};
      sync_reg <= meta_reg;
    end
  end

  // -------------------------------------------------
  // enable pin open-drain pull-down
  // -------------------------------------------------
  // pulled while a fault stands; release is left to the external rc
  always @(posedge clock)
  begin
    if (!resetn)
      pull_reg <= 1'b0;
    else
      pull_reg <= sync_reg[6] | sync_reg[7];
  end

  assign enable_out = 1'b0;
  assign enable_oe = pull_reg;

  // -------------------------------------------------
  // one chopper per bridge
  // -------------------------------------------------
  bcc_bridge #(.CNT_W(CNT_W), .TOFF_CYC(TOFF_A_CYC)) u_bridge_a (
    .clock(clock),
    .resetn(resetn),
    .enable(sync_reg[5] & ~pull_reg),
    .phase(sync_reg[2]),
    .slow_decay(sync_reg[4]),
    .over_ref(sync_reg[0]),
    .hs1_reg(hs1_a),
    .ls1_reg(ls1_a),
    .hs2_reg(hs2_a),
    .ls2_reg(ls2_a),
    .chopping_reg(chopping_a)
  );

  bcc_bridge #(.CNT_W(CNT_W), .TOFF_CYC(TOFF_B_CYC)) u_bridge_b (
    .clock(clock),
    .resetn(resetn),
    .enable(sync_reg[5] & ~pull_reg),
    .phase(sync_reg[3]),
    .slow_decay(sync_reg[4]),
    .over_ref(sync_reg[1]),
    .hs1_reg(hs1_b),
    .ls1_reg(ls1_b),
    .hs2_reg(hs2_b),
    .ls2_reg(ls2_b),
    .chopping_reg(chopping_b)
  );
endmodule
`default_nettype wire

// ==== sim/bcc_top_asserts.sv ====
// bcc_top_asserts.sv: port-level checks for the dual bridge chopper
// assumes it is bound into bcc_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module bcc_chk #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] TOFF_A_CYC = 16'h012c,
  parameter [CNT_W-1:0] TOFF_B_CYC = 16'h012c
) (
  input wire clock,
  input wire resetn,
  input wire enable_in,
  input wire enable_out,
  input wire enable_oe,
  input wire fault_overcurrent,
  input wire fault_thermal,
  input wire hs1_a,
  input wire ls1_a,
  input wire hs2_a,
  input wire ls2_a,
  input wire chopping_a,
  input wire hs1_b,
  input wire ls1_b,
  input wire hs2_b,
  input wire ls2_b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire drv_a = (hs1_a & ls2_a) | (hs2_a & ls1_a);
  wire [7:0] gates = {hs1_a, ls1_a, hs2_a, ls2_a, hs1_b, ls1_b, hs2_b, ls2_b};
  reg [15:0] on_cnt_reg;
  reg [15:0] on_len_reg;
  reg [15:0] off_cnt_reg;
  // run lengths; on_len keeps the last drive run once it ends
  always @(posedge clock)
  begin
    on_cnt_reg <= drv_a ? on_cnt_reg + 16'h0001 : 16'h0000;
    if (drv_a) on_len_reg <= on_cnt_reg + 16'h0001;
    off_cnt_reg <= chopping_a ? off_cnt_reg + 16'h0001 : 16'h0000;
  end
  a_gap_leg1_a: assert property (($fell(hs1_a) |=> !ls1_a [*8]) and ($fell(ls1_a) |=> !hs1_a [*8]))
    else $error("leg 1 gap too short");
  a_gap_leg2_a: assert property (($fell(hs2_a) |=> !ls2_a [*8]) and ($fell(ls2_a) |=> !hs2_a [*8]))
    else $error("leg 2 gap too short");
  a_no_shoot_b: assert property (!(hs1_b && ls1_b) && !(hs2_b && ls2_b))
    else $error("bridge b leg conducts through");
  a_enable_off: assert property (!enable_in [*5] |-> gates == 8'h00)
    else $error("gate on while disabled");
  a_fault_pull: assert property ((fault_overcurrent || fault_thermal) [*5] |-> enable_oe)
    else $error("fault did not pull enable");
  a_pin_low: assert property (enable_oe |-> !enable_out)
    else $error("enable pulled high");
  a_trip_off_a: assert property ($rose(chopping_a) |-> ##[0:1] !drv_a)
    else $error("trip left bridge driving");
  a_min_on_a: assert property ($rose(chopping_a) |-> on_len_reg >= 16'h0026)
    else $error("on time below minimum");
  a_off_len_a: assert property ($fell(chopping_a) |-> off_cnt_reg >= TOFF_A_CYC)
    else $error("off time cut short");
endmodule
bind bcc_top bcc_chk #(.CNT_W(CNT_W), .TOFF_A_CYC(TOFF_A_CYC), .TOFF_B_CYC(TOFF_B_CYC)) bcc_chk_i (
  .clock(clock), .resetn(resetn), .enable_in(enable_in), .enable_out(enable_out),
  .enable_oe(enable_oe), .fault_overcurrent(fault_overcurrent), .fault_thermal(fault_thermal),
  .hs1_a(hs1_a), .ls1_a(ls1_a), .hs2_a(hs2_a), .ls2_a(ls2_a), .chopping_a(chopping_a),
  .hs1_b(hs1_b), .ls1_b(ls1_b), .hs2_b(hs2_b), .ls2_b(ls2_b));
`default_nettype wire

// ==== sim/bcc_winding.sv ====
// bcc_winding.sv: winding plus sense resistor behind one bridge
// assumes registered gate drives on the same clock
`timescale 1ns/10ps
`default_nettype none
module bcc_winding (
  input wire logic clock,
  input wire logic hs1,
  input wire logic ls1,
  input wire logic hs2,
  input wire logic ls2,
  input wire logic [15:0] limit,
  output logic over_ref
);
  logic [15:0] cur_reg = 16'h0000;
  // current builds while driven, decays otherwise; direction ignored
  always @(posedge clock)
  begin
    if ((hs1 && ls2) || (hs2 && ls1)) cur_reg <= cur_reg + 16'h0001;
    else if (cur_reg != 16'h0000) cur_reg <= cur_reg - 16'h0001;
  end
  // a low limit answers promptly, a high one slowly
  assign over_ref = cur_reg >= limit;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// tb.sv: self-checking bench for bcc_top with two winding models
// assumes bcc_defs.vh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.vh"
module tb;
  localparam int TOFF = 50;
  localparam int GAP = `BCC_GAP_CYC;
  localparam int TON_MIN = `BCC_TON_MIN_CYC;
  logic clock = 0, resetn = 0, en_drv = 1, f_oc = 0, f_th = 0, slow = 0, ph = 1, ph_b = 1;
  wire en_pin, en_out, en_oe, o_a, o_b, hs1_a, ls1_a, hs2_a, ls2_a, ch_a;
  wire hs1_b, ls1_b, hs2_b, ls2_b, ch_b;
  wire [3:0] ga = {hs1_a, ls1_a, hs2_a, ls2_a};
  int err_count = 0, num_checks = 0, cyc = 0;
  // open-drain enable wire: the device pull-down wins
  assign en_pin = en_oe ? en_out : en_drv;
  always #20 clock = ~clock;
  bcc_top #(.TOFF_A_CYC(16'h0032), .TOFF_B_CYC(16'h0032)) bcc_top_i (
    .clock(clock), .resetn(resetn), .enable_in(en_pin), .enable_out(en_out),
    .enable_oe(en_oe), .fault_overcurrent(f_oc), .fault_thermal(f_th), .slow_decay(slow),
    .phase_a(ph), .phase_b(ph_b), .over_ref_a(o_a), .over_ref_b(o_b), .hs1_a(hs1_a),
    .ls1_a(ls1_a), .hs2_a(hs2_a), .ls2_a(ls2_a), .chopping_a(ch_a), .hs1_b(hs1_b),
    .ls1_b(ls1_b), .hs2_b(hs2_b), .ls2_b(ls2_b), .chopping_b(ch_b));
  bcc_winding bcc_winding_i (.clock(clock), .hs1(hs1_a), .ls1(ls1_a), .hs2(hs2_a),
    .ls2(ls2_a), .limit(16'h0014), .over_ref(o_a));
  bcc_winding bcc_winding_b_i (.clock(clock), .hs1(hs1_b), .ls1(ls1_b), .hs2(hs2_b),
    .ls2(ls2_b), .limit(16'hffff), .over_ref(o_b));
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // bounded wait for the off-time flag of bridge a
  task wait_ch(input logic v);
    int n;
    for (n = 0; n < 3000 && ch_a !== v; n++)
      @(negedge clock);
  endtask
  // fast decay trip, rectifier, off length, then next on length
  task t_fast;
    int n;
    wait_ch(0);
    wait_ch(1);
    chk("fast_off", 4'h0, ga);
    chk("b_drives", 1, hs1_b & ls2_b);
    chk("b_no_chop", 0, ch_b);
    repeat (GAP + 2) @(negedge clock);
    chk("fast_rect", 4'b0100, ga);
    for (n = GAP + 2; n < 400 && ga !== 4'b1001; n++)
      @(negedge clock);
    chk("off_time", 1, n >= TOFF + GAP - 1 && n <= TOFF + GAP + 3);
    for (n = 0; n < 400 && ch_a !== 1'b1; n++)
      @(negedge clock);
    chk("min_on", 1, n >= TON_MIN && n <= TON_MIN + 3);
  endtask
  // direction change on bridge b alone: all off, gap, on the other way
  task t_dir;
    ph_b = 0;
    repeat (10) @(negedge clock);
    chk("dir_gap", 4'h0, {hs1_b, ls1_b, hs2_b, ls2_b});
    repeat (2 * GAP) @(negedge clock);
    chk("dir_b", 4'b0110, {hs1_b, ls1_b, hs2_b, ls2_b});
    chk("dir_no_chop", 0, ch_b);
  endtask
  // slow decay keeps the high side and rectifies with the other
  task t_slow;
    wait_ch(0);
    slow = 1;
    wait_ch(1);
    chk("slow_off", 4'b1000, ga);
    repeat (GAP + 2) @(negedge clock);
    chk("slow_rect", 4'b1010, ga);
    wait_ch(0);
    slow = 0;
  endtask
  // enable low and each fault kill all gates
  task t_en;
    int i;
    en_drv = 0;
    repeat (5) @(negedge clock);
    chk("en_off", 8'h00, {ga, hs1_b, ls1_b, hs2_b, ls2_b});
    en_drv = 1;
    for (i = 1; i < 3; i++)
    begin
      {f_oc, f_th} = i[1:0];
      repeat (5) @(negedge clock);
      chk("fault_pull", 1, en_oe);
      chk("fault_off", 8'h00, {ga, hs1_b, ls1_b, hs2_b, ls2_b});
      {f_oc, f_th} = 2'b00;
      repeat (5) @(negedge clock);
      chk("fault_free", 0, en_oe);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // timeout well past the expected run length
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (4) @(negedge clock);
    resetn = 1;
    t_fast;
    t_slow;
    t_dir;
    t_en;
    print_verdict;
  end
endmodule
`default_nettype wire
